//--- src/light_cfg_pkg.sv
// package: register map, field layout and timing for the light channel
package light_cfg_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PARAMS = 8'h84;
  localparam logic [7:0] ADDR_RES_HI = 8'h85;
  localparam logic [7:0] ADDR_RES_LO = 8'h86;

  // field positions inside light_measure_params
  localparam int CONT_BIT = 7;
  localparam int RATE_LSB = 4;
  localparam int OFS_BIT = 3;
  localparam int AVG_LSB = 0;

  // cont=0, rate=000, offset comp=1, averaging=101
  localparam logic [7:0] PARAMS_RESET = 8'h0d;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SEC_NS = 1000000000;
  localparam int CYCLES_PER_SEC = SEC_NS / CLK_PERIOD_NS;
  // settling pause between single conversions, skipped in continuous mode
  localparam int CONV_GAP_NS = 100;
  localparam int CONV_GAP_CYCLES =
    (CONV_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // layout matches the register bit for bit
  typedef struct packed {
    logic cont;
    logic [2:0] rate;
    logic ofs_en;
    logic [2:0] avg;
  } params_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OFS_WAIT = 3'h1,
    ST_GAP = 3'h3,
    ST_SMP_WAIT = 3'h2,
    ST_STORE = 3'h6
  } meas_state_type;

  // samples per second for each rate code
  function automatic logic [3:0] rate_sps(input logic [2:0] code);
    unique case (code)
      3'h6: rate_sps = 4'h8;
      3'h7: rate_sps = 4'ha;
      default: rate_sps = 4'({1'b0, code} + 4'h1);
    endcase
  endfunction : rate_sps

endpackage : light_cfg_pkg

//--- src/light_avg_accum.sv
// accumulator that sums single conversions and returns their mean
module light_avg_accum
  import light_cfg_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int SHIFT_W = 3
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic add_in,
  input wire logic [DATA_W-1:0] sample_in,
  input wire logic [SHIFT_W-1:0] shift_in,
  output logic [DATA_W-1:0] mean_out
);

  localparam int ACC_W = DATA_W + (1 << SHIFT_W) - 1;

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;

  // clear wins over add: a new cycle never inherits old sums
  always_comb begin
    acc_nxt = acc_r;
    if (clear_in) begin
      acc_nxt = '0;
    end else if (add_in) begin
      acc_nxt = acc_r + ACC_W'(sample_in);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // power-of-two count makes the mean a plain shift
  assign mean_out = DATA_W'(acc_r >> shift_in);

endmodule : light_avg_accum

//--- src/light_channel.sv
// ambient light parameter register, measurement sequencer and result
// Overview of operation
// R1: bit 7 enables continuous back-to-back conversions; resets to zero.
// R2: host uses continuous mode only with on-demand, never self-timed.
// R3: rate codes 0-5 give 1-6 samples/s, 6 gives 8, 7 gives 10.
// R4: bit 3 enables automatic offset compensation; resets to enabled.
// R5: with compensation on, offset measured first and subtracted from reading.
// R6: each measurement performs two to the averaging value conversions.
// R7: stored result is the mean of that cycle's conversions.
// R8: averaging field is bits 2:0, reset value 101, 32 conversions.
// R9: while self-timed runs, new parameters wait until the mode is cycled.
// R10: result high byte at 85h, low byte at 86h.
// R11: result bytes are read-only; writes leave them unchanged.
// R12: host changes parameters only while self-timed enable is zero.
// R13: host writes parameters only while the on-demand trigger reads zero.
// R14: both result bytes update together at completion, else hold.
module light_channel
  import light_cfg_pkg::*;
#(
  parameter int SEC_CYCLES = CYCLES_PER_SEC,
  parameter int GAP_CYCLES = CONV_GAP_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  // register access from the serial interface
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // measurement control
  input wire logic selftimed_en_in,
  input wire logic light_single_shot_trigger_in,
  output logic busy_out,
  output logic result_ready_out,
  // converter
  output logic conv_req_out,
  output logic conv_offset_out,
  input wire logic conv_done_in,
  input wire logic [15:0] conv_data_in
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  params_type params_r, params_nxt;
  params_type act_r, act_nxt;
  logic timed_d_r;
  logic [7:0] rdata_r, rdata_nxt;
  logic [15:0] result_r, result_nxt;

  meas_state_type state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [15:0] gap_r, gap_nxt;
  logic [31:0] tick_r, tick_nxt;
  logic [15:0] ofs_r, ofs_nxt;
  logic req_r, req_nxt;
  logic ofs_phase_r, ofs_phase_nxt;
  logic ready_r, ready_nxt;

  logic [15:0] mean;
  logic [8:0] n_conv;
  logic [31:0] period;
  logic start;
  logic acc_clear;
  logic acc_add;

  // register file; only the parameter register is writable
  always_comb begin
    params_nxt = params_r;
    if (reg_wr_in && reg_addr_in == ADDR_PARAMS) begin
      params_nxt = params_type'(reg_wdata_in); // R1 R4 R8
    end
    // live copy follows the register except while self-timed runs
    act_nxt = act_r;
    if (!selftimed_en_in || !timed_d_r) begin
      act_nxt = params_nxt; // R9
    end
    unique case (reg_addr_in)
      ADDR_PARAMS: rdata_nxt = params_r;
      ADDR_RES_HI: rdata_nxt = result_r[15:8]; // R10
      ADDR_RES_LO: rdata_nxt = result_r[7:0]; // R10
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      params_r <= params_type'(PARAMS_RESET); // R1 R4 R8
      act_r <= params_type'(PARAMS_RESET);
      timed_d_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      params_r <= params_nxt;
      act_r <= act_nxt;
      timed_d_r <= selftimed_en_in;
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // rate divider for self-timed operation
  // ---------------------------------------------------------------
  always_comb begin
    unique case (act_r.rate) // R3
      3'h0: period = 32'(SEC_CYCLES / 1);
      3'h1: period = 32'(SEC_CYCLES / 2);
      3'h2: period = 32'(SEC_CYCLES / 3);
      3'h3: period = 32'(SEC_CYCLES / 4);
      3'h4: period = 32'(SEC_CYCLES / 5);
      3'h5: period = 32'(SEC_CYCLES / 6);
      3'h6: period = 32'(SEC_CYCLES / 8);
      3'h7: period = 32'(SEC_CYCLES / 10);
    endcase
  end

  // self-timed start fires at count zero, on-demand start on trigger
  assign start = (state_r == ST_IDLE) &&
                 (selftimed_en_in ? (tick_r == 32'h0)
                                  : light_single_shot_trigger_in);
  assign n_conv = 9'h001 << act_r.avg; // R6

  // ---------------------------------------------------------------
  // measurement sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    gap_nxt = gap_r;
    ofs_nxt = ofs_r;
    req_nxt = 1'b0;
    ofs_phase_nxt = ofs_phase_r;
    ready_nxt = 1'b0;
    result_nxt = result_r; // R11 R14
    acc_clear = 1'b0;
    acc_add = 1'b0;
    tick_nxt = tick_r;
    if (!selftimed_en_in || tick_r == period - 32'h1) begin
      tick_nxt = 32'h0;
    end else begin
      tick_nxt = tick_r + 32'h1;
    end
    unique case (state_r)
      ST_IDLE: begin
        if (start) begin
          acc_clear = 1'b1;
          cnt_nxt = 8'h00;
          ofs_nxt = 16'h0000;
          gap_nxt = 16'h0000;
          if (act_r.ofs_en) begin
            req_nxt = 1'b1; // R5
            ofs_phase_nxt = 1'b1;
            state_nxt = ST_OFS_WAIT;
          end else begin
            state_nxt = ST_GAP;
          end
        end
      end
      ST_OFS_WAIT: begin
        if (conv_done_in) begin
          ofs_nxt = conv_data_in; // R5
          ofs_phase_nxt = 1'b0;
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        // continuous mode drops the settling pause
        if (act_r.cont || gap_r >= 16'(GAP_CYCLES - 1)) begin // R1
          req_nxt = 1'b1;
          state_nxt = ST_SMP_WAIT;
        end else begin
          gap_nxt = gap_r + 16'h0001;
        end
      end
      ST_SMP_WAIT: begin
        if (conv_done_in) begin
          acc_add = 1'b1; // R7
          cnt_nxt = cnt_r + 8'h01;
          gap_nxt = 16'h0000;
          if (9'(cnt_r) + 9'h001 == n_conv) begin // R6
            state_nxt = ST_STORE;
          end else begin
            state_nxt = ST_GAP;
          end
        end
      end
      ST_STORE: begin
        // clamp: offset above the mean reads as dark, not a wrap
        result_nxt = (mean > ofs_r) ? mean - ofs_r : 16'h0000; // R5 R7 R14
        ready_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      gap_r <= 16'h0000;
      tick_r <= 32'h0;
      ofs_r <= 16'h0000;
      req_r <= 1'b0;
      ofs_phase_r <= 1'b0;
      ready_r <= 1'b0;
      result_r <= RESULT_RESET;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      gap_r <= gap_nxt;
      tick_r <= tick_nxt;
      ofs_r <= ofs_nxt;
      req_r <= req_nxt;
      ofs_phase_r <= ofs_phase_nxt;
      ready_r <= ready_nxt;
      result_r <= result_nxt;
    end
  end

  light_avg_accum #(
    .DATA_W(16),
    .SHIFT_W(3)
  ) u_accum (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(acc_clear),
    .add_in(acc_add),
    .sample_in(conv_data_in),
    .shift_in(act_r.avg),
    .mean_out(mean)
  );

  assign reg_rdata_out = rdata_r;
  assign busy_out = (state_r != ST_IDLE);
  assign result_ready_out = ready_r;
  assign conv_req_out = req_r;
  assign conv_offset_out = ofs_phase_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // checked on the first edge out of reset, since reset itself disables it
  reset_value_a: assert property ($fell(rst_in) |-> // R1 R4 R8
    params_r == PARAMS_RESET && result_r == RESULT_RESET)
    else $error("reset values wrong");
  param_write_a: assert property (reg_wr_in && // R1 R4
    reg_addr_in == ADDR_PARAMS |=> params_r == $past(reg_wdata_in))
    else $error("param write not stored");
  timed_hold_a: assert property (selftimed_en_in && // R9
    $past(selftimed_en_in) |-> $stable(act_r))
    else $error("params changed while self-timed");
  result_hold_a: assert property ($past(state_r) != ST_STORE |-> // R11 R14
    $stable(result_r)) else $error("result changed outside store");
  result_read_a: assert property (reg_addr_in == ADDR_RES_LO ##1 // R10
    $stable(result_r) |-> reg_rdata_out == result_r[7:0])
    else $error("low result byte read wrong");
  offset_first_a: assert property (start && act_r.ofs_en |=> // R5
    conv_req_out && conv_offset_out) else $error("offset not first");
  conv_count_a: assert property (state_r == ST_STORE |-> // R6
    9'(cnt_r) == n_conv) else $error("wrong conversion count");
  mean_store_a: assert property (state_r == ST_STORE && // R7
    ofs_r == 16'h0000 |=> result_r == $past(mean))
    else $error("result is not the mean");
  cont_gap_a: assert property (state_r == ST_GAP && act_r.cont |=> // R1
    conv_req_out && state_r == ST_SMP_WAIT) else $error("gap in cont");
  // start spacing bounded by the samples-per-second table, not the divider
  rate_tick_a: assert property (selftimed_en_in |-> // R3
    tick_r < 32'(SEC_CYCLES / rate_sps(act_r.rate)))
    else $error("self-timed period too long");

  single_shot_c: cover property (!selftimed_en_in && start ##[1:600]
    result_ready_out);
  offset_run_c: cover property (conv_offset_out ##[1:600] result_ready_out);
  cont_run_c: cover property (act_r.cont && state_r == ST_GAP);
  timed_run_c: cover property (selftimed_en_in && result_ready_out);

endmodule : light_channel

//--- tb/light_conv_model.sv
// converter stand-in that answers each conversion request
module light_conv_model (
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic req_in,
  input wire logic offset_in,
  input wire logic [15:0] level_in,
  input wire logic [15:0] dark_in,
  input wire logic [3:0] lat_in,
  output logic done_out,
  output logic [15:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_r = -1;
  logic odd_r = 1'b0;
  logic dark_r = 1'b0;
  // ---------------------------------------------------------------
  // answer lat_in+1 cycles after req_in is seen; samples alternate level, level+1
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    data_out <= ~data_out; // data is only valid with done
    if (clr_in) odd_r <= 1'b0;
    if (req_in) begin
      wait_r <= lat_in;
      dark_r <= offset_in;
    end else if (wait_r > 0) begin
      wait_r <= wait_r - 1;
    end else if (wait_r == 0) begin
      wait_r <= -1;
      done_out <= 1'b1;
      data_out <= dark_r ? dark_in : level_in + {15'h0, odd_r};
      if (!dark_r) odd_r <= ~odd_r;
    end
  end
endmodule : light_conv_model

//--- tb/test_ambient_light_config_result.sv
// self-checking bench for the light parameter and result registers
module test_ambient_light_config_result import light_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 1000;
  localparam int GAP = 8;
  logic clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, st = 1'b0;
  logic trig = 1'b0, busy, rdy, req, ofs, done;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, rdata, b, c;
  logic [15:0] data, level = 16'h0, dark = 16'h0, last = 16'h0;
  logic [3:0] lat = 4'h1;
  int bad_count = 0, cmp_count = 0, seed = 32'h8558;
  int n_req, n_ofs, gap_min, since, cyc = 0, t_req = 0, t_prev = 0;
  light_channel #(.SEC_CYCLES(SEC), .GAP_CYCLES(GAP)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(rdata), .selftimed_en_in(st),
    .light_single_shot_trigger_in(trig), .busy_out(busy),
    .result_ready_out(rdy), .conv_req_out(req), .conv_offset_out(ofs),
    .conv_done_in(done), .conv_data_in(data));
  light_conv_model conv (.clk_in(clk_in), .clr_in(!busy), .req_in(req),
    .offset_in(ofs), .level_in(level), .dark_in(dark), .lat_in(lat),
    .done_out(done), .data_out(data));
  always #2 clk_in = ~clk_in;
  // ---------------------------------------------------------------
  // request counting and spacing between conversions
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    cyc++;
    since++;
    if (done === 1'b1) since = 0;
    if (req === 1'b1) begin
      if (ofs === 1'b1) n_ofs++;
      else n_req++;
      if (since < gap_min) gap_min = since;
      t_prev = t_req;
      t_req = cyc;
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    @(negedge clk_in);
    d = rdata;
  endtask : rd
  // bounded wait for the one-cycle completion pulse
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (rdy !== 1'b1 && k < 20000);
    if (k >= 20000) bad_count++;
  endtask : wait_rdy
  function automatic int sps(input int code);
    return code < 6 ? code + 1 : (code == 6 ? 8 : 10);
  endfunction : sps
  // one on-demand measurement with random light and offset levels
  task automatic meas(input logic [7:0] p);
    level = $random(seed) & 16'hfffe;
    dark = $random(seed) & 16'h0fff;
    if (p[2:0] == 3'h3) level = 16'h0004; // offset above reading
    lat = $random(seed) & 4'h7; // prompt and slow converter
    wr(ADDR_PARAMS, p);
    n_req = 0;
    n_ofs = 0;
    gap_min = 999;
    @(negedge clk_in);
    trig = 1'b1;
    @(negedge clk_in);
    trig = 1'b0;
    chk(busy, 1'b1);
    wait_rdy();
    chk(busy, 1'b0);
    chk(n_req, 16'h1 << p[2:0]);
    chk(n_ofs, p[3]);
    if (p[2:0] != 3'h0 || p[3]) chk(gap_min < GAP, p[7]);
    last = !p[3] ? level : (level > dark ? level - dark : 16'h0);
    rd(ADDR_RES_HI, b);
    rd(ADDR_RES_LO, c);
    chk({b, c}, last);
  endtask : meas
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    rd(ADDR_PARAMS, b);
    chk(b, {1'b0, 3'h0, 1'b1, 3'h5});
    rd(ADDR_RES_HI, b);
    rd(ADDR_RES_LO, c);
    chk({b, c}, 16'h0);
    rd(8'h90, b);
    chk(b, 8'h00);
    for (int a = 0; a < 8; a++) meas({$random(seed)} & 8'hf8 | a[7:0]);
    // result bytes ignore writes and hold between measurements
    wr(ADDR_RES_HI, $random(seed));
    wr(ADDR_RES_LO, $random(seed));
    rd(ADDR_RES_HI, b);
    rd(ADDR_RES_LO, c);
    chk({b, c}, last);
    // self-timed start spacing for every rate code
    for (int r = 0; r < 8; r++) begin
      wr(ADDR_PARAMS, {1'b0, r[2:0], 4'h0});
      st = 1'b1;
      wait_rdy();
      wait_rdy();
      chk(t_req - t_prev, SEC / sps(r));
      st = 1'b0;
    end
    // a write while self-timed runs is held back
    wr(ADDR_PARAMS, 8'h00);
    st = 1'b1;
    wait_rdy();
    wr(ADDR_PARAMS, 8'h02);
    n_req = 0;
    wait_rdy();
    chk(n_req, 16'h1);
    st = 1'b0;
    rd(ADDR_PARAMS, b);
    chk(b, 8'h02);
    meas(8'h02);
    // continuous mode with offset above the reading: clamp to zero
    meas(8'h8b);
    // reset while idle after the last measurement restores the parameter default
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    rd(ADDR_PARAMS, b);
    chk(b, 8'h0d);
    results();
  end
  initial begin
    #(60000 * 4);
    bad_count++;
    results();
  end
endmodule : test_ambient_light_config_result
